//--- phyx_pkg.sv
package phyx_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam int IRQ_W = 3;
	localparam int STRAP_SYNC_CYC = 2;
	localparam int STRETCH_CYC_DEF = 16;

	// register map
	localparam logic [4:0] ADR_RSVD_A = 5'h17;
	localparam logic [4:0] ADR_RSVD_B = 5'h18;
	localparam logic [4:0] ADR_PHY_CTRL = 5'h19;
	localparam logic [4:0] ADR_TENBASE = 5'h1A;
	localparam logic [4:0] ADR_IRQ_STAT = 5'h1B;
	localparam logic [4:0] ADR_IRQ_CLR = 5'h1C;
	localparam logic [4:0] ADR_IRQ_EN = 5'h1D;

	// phy control word fields
	localparam int PC_SEQ_SEL = 11;
	localparam int PC_RESULT = 10;
	localparam int PC_RUN = 9;
	localparam int PC_BYPASS = 8;
	localparam int PC_PAUSE = 7;
	localparam int PC_ONE = 6;
	localparam int PC_DUPLEX_INDICATOR_CFG = 5;
	localparam int PC_ADDR_HI = 4;
	localparam int PC_ADDR_LO = 0;

	// tenbase control/status fields
	localparam int TB_LB10 = 8;
	localparam int TB_LINK_PULSE_DISABLE = 7;
	localparam int TB_FORCE = 6;
	localparam int TB_RSV5 = 5;
	localparam int TB_POL = 4;
	localparam int TB_RSV3 = 3;
	localparam int TB_RSV2 = 2;
	localparam int TB_HB_DIS = 1;
	localparam int TB_JAB_DIS = 0;
	localparam logic [15:0] TB_RW_MASK = 16'h01EF;
	localparam logic [15:0] TB_RESET = 16'h0004;

	// interrupt status bits
	localparam int IRQ_POL = 0;
	localparam int IRQ_PASS = 1;
	localparam int IRQ_RSVD_WR = 2;

	typedef enum logic [1:0] {
		ST_STRAP = 2'b01,
		ST_RUN = 2'b10
	} boot_e;
endpackage

//--- indicator_if.sv
`timescale 1ns/1ps
interface indicator_if;
	logic [2:0] raw;
	logic [2:0] led;
	logic bypass;
	modport src (output raw, output bypass, input led);
	modport strt (input raw, input bypass, output led);
endinterface

//--- ind_stretcher.sv
`timescale 1ns/1ps
module ind_stretcher import phyx_pkg::*; #(
	parameter int STRETCH_CYC = STRETCH_CYC_DEF
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// indicators
	indicator_if.strt ind
);
	localparam int CW = $clog2(STRETCH_CYC + 1);
	localparam logic [CW-1:0] CNT_LOAD = CW'(STRETCH_CYC);
	logic [CW-1:0] cnt [3];

	// refused at elaboration: a zero hold would never load the counter
	if (STRETCH_CYC < 1) begin : g_bad_stretch
		$error("stretch count must be at least one");
	end

	// one process per concern keeps a single driver on each array
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int c = 0; c < 3; c++) begin
				cnt[c] <= '0;
			end
		end else begin
			for (int c = 0; c < 3; c++) begin
				if (ind.raw[c]) begin
					cnt[c] <= CNT_LOAD;
				end else if (cnt[c] != '0) begin
					cnt[c] <= cnt[c] - CW'(1);
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ind.led <= '0;
		end else begin
			for (int c = 0; c < 3; c++) begin
				// bypass shows the raw activity with no hold time
				ind.led[c] <= ind.bypass ? ind.raw[c] : (ind.raw[c] | (cnt[c] != '0));
			end
		end
	end
endmodule // ind_stretcher

//--- phy_extended_control_regs.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module phy_extended_control_regs import phyx_pkg::*; #(
	parameter int STRETCH_CYC = STRETCH_CYC_DEF
) (
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_N,
	// register port
	input wire logic [ADDR_W-1:0] I_ADDR,
	input wire logic [DATA_W-1:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [DATA_W-1:0] O_RDATA,
	// strap pins
	input wire logic [4:0] I_STRAP_ADDR,
	input wire logic I_STRAP_DUPLEX_INDICATOR_CFG,
	// link state from the transceiver core
	input wire logic I_BASIC_LOOPBACK,
	input wire logic I_SPEED_100,
	input wire logic I_FULL_DUPLEX,
	input wire logic I_LINK_MON_10,
	input wire logic I_POLARITY_INVERTED,
	input wire logic I_LOCAL_PAUSE,
	input wire logic I_PARTNER_PAUSE,
	input wire logic I_SELFTEST_PASS,
	// raw activity
	input wire logic I_RX_ACT,
	input wire logic I_TX_ACT,
	input wire logic I_COL_ACT,
	// controls to the core
	output logic O_SELFTEST_RUN,
	output logic O_SELFTEST_LONG_SEQ,
	output logic [4:0] O_PORT_ADDR,
	output logic O_TEN_LOOPBACK_EN,
	output logic O_LINK_PULSE_EN,
	output logic O_LINK_GOOD_10,
	output logic O_HEARTBEAT_EN,
	output logic O_JABBER_EN,
	output logic O_PHY_STATUS_REGISTER_POLARITY,
	// indicators
	output logic O_RX_IND,
	output logic O_TX_IND,
	output logic O_COL_IND,
	output logic O_DUPLEX_IND,
	// interrupt
	output logic O_IRQ
);
	logic [4:0] strap_addr_s1;
	logic [4:0] strap_addr_s2;
	logic strap_cfg_s1;
	logic strap_cfg_s2;
	logic strap_cfg;
	boot_e boot;
	logic [1:0] strap_cnt;
	logic [15:0] rsvd_a;
	logic [15:0] rsvd_b;
	logic seq_sel;
	logic run;
	logic result;
	logic bypass;
	logic duplex_indicator_cfg;
	logic [4:0] port_addr;
	logic [15:0] tb;
	logic pol;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_en;
	logic [IRQ_W-1:0] irq_set;
	logic wr_ctrl;
	logic wr_tb;
	logic rd_tb;
	logic pause;
	logic [15:0] ctrl_word;
	logic [15:0] tb_word;
	logic [15:0] next_rdata;
	logic pass_q;

	function automatic logic hit(input logic stb, input logic [4:0] a, input logic [4:0] r);
		hit = stb && (a == r);
	endfunction

	assign wr_ctrl = hit(I_WR, I_ADDR, ADR_PHY_CTRL);
	assign wr_tb = hit(I_WR, I_ADDR, ADR_TENBASE);
	assign rd_tb = hit(I_RD, I_ADDR, ADR_TENBASE);
	assign pause = I_LOCAL_PAUSE & I_PARTNER_PAUSE;

	// straps are pins: two flops first
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			strap_addr_s1 <= '0;
			strap_addr_s2 <= '0;
			strap_cfg_s1 <= 1'b0;
			strap_cfg_s2 <= 1'b0;
		end else begin
			strap_addr_s1 <= I_STRAP_ADDR;
			strap_addr_s2 <= strap_addr_s1;
			strap_cfg_s1 <= I_STRAP_DUPLEX_INDICATOR_CFG;
			strap_cfg_s2 <= strap_cfg_s1;
		end
	end

	// straps are caught once the synchroniser has filled after release
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			boot <= ST_STRAP;
			strap_cnt <= '0;
		end else begin
			unique case (boot)
				ST_STRAP: begin
					strap_cnt <= strap_cnt + 2'(1);
					if (strap_cnt == 2'(STRAP_SYNC_CYC)) begin
						boot <= ST_RUN;
					end
				end
				ST_RUN: strap_cnt <= strap_cnt;
			endcase
		end
	end

	// reserved words: plain storage, software is expected to leave them alone
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rsvd_a <= '0;
			rsvd_b <= '0;
		end else begin
			if (hit(I_WR, I_ADDR, ADR_RSVD_A)) begin
				rsvd_a <= I_WDATA;
			end
			if (hit(I_WR, I_ADDR, ADR_RSVD_B)) begin
				rsvd_b <= I_WDATA;
			end
		end
	end

	// phy control word
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			seq_sel <= 1'b0;
			run <= 1'b0;
			bypass <= 1'b0;
			duplex_indicator_cfg <= 1'b0;
			port_addr <= '0;
			strap_cfg <= 1'b0;
		end else if (boot == ST_STRAP) begin
			if (strap_cnt == 2'(STRAP_SYNC_CYC)) begin
				duplex_indicator_cfg <= strap_cfg_s2;
				strap_cfg <= strap_cfg_s2;
				port_addr <= strap_addr_s2;
			end
		end else if (wr_ctrl) begin
			seq_sel <= I_WDATA[PC_SEQ_SEL];
			run <= I_WDATA[PC_RUN];
			bypass <= I_WDATA[PC_BYPASS];
			duplex_indicator_cfg <= I_WDATA[PC_DUPLEX_INDICATOR_CFG];
			port_addr <= I_WDATA[PC_ADDR_HI:PC_ADDR_LO];
		end
	end

	// result latch: a pass in the clearing cycle still lands
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			result <= 1'b0;
		end else if (run && I_SELFTEST_PASS) begin
			result <= 1'b1;
		end else if (wr_ctrl) begin
			result <= 1'b0;
		end
	end

	// tenbase word, writable bits only
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			tb <= TB_RESET;
		end else if (wr_tb) begin
			tb <= I_WDATA & TB_RW_MASK;
		end
	end

	// polarity latch: cleared only by a read of the tenbase word
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pol <= 1'b0;
		end else if (I_POLARITY_INVERTED) begin
			pol <= 1'b1;
		end else if (rd_tb) begin
			pol <= 1'b0;
		end
	end

	always_comb begin
		ctrl_word = '0;
		ctrl_word[PC_SEQ_SEL] = seq_sel;
		ctrl_word[PC_RESULT] = result;
		ctrl_word[PC_RUN] = run;
		ctrl_word[PC_BYPASS] = bypass;
		ctrl_word[PC_PAUSE] = pause;
		ctrl_word[PC_ONE] = 1'b1;
		ctrl_word[PC_DUPLEX_INDICATOR_CFG] = duplex_indicator_cfg;
		ctrl_word[PC_ADDR_HI:PC_ADDR_LO] = port_addr;
	end

	always_comb begin
		tb_word = tb & TB_RW_MASK;
		tb_word[TB_POL] = pol;
	end

	always_comb begin
		unique case (I_ADDR)
			ADR_RSVD_A: next_rdata = rsvd_a;
			ADR_RSVD_B: next_rdata = rsvd_b;
			ADR_PHY_CTRL: next_rdata = ctrl_word;
			ADR_TENBASE: next_rdata = tb_word;
			ADR_IRQ_STAT: next_rdata = 16'(irq_stat);
			ADR_IRQ_EN: next_rdata = 16'(irq_en);
			default: next_rdata = '0;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_RDATA <= '0;
		end else begin
			O_RDATA <= I_RD ? next_rdata : '0;
		end
	end

	// interrupts: sticky status, write-one-to-clear, set beats clear
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pass_q <= 1'b0;
		end else begin
			pass_q <= result;
		end
	end

	always_comb begin
		irq_set = '0;
		irq_set[IRQ_POL] = I_POLARITY_INVERTED & ~pol;
		irq_set[IRQ_PASS] = result & ~pass_q;
		irq_set[IRQ_RSVD_WR] = hit(I_WR, I_ADDR, ADR_RSVD_A) | hit(I_WR, I_ADDR, ADR_RSVD_B);
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			irq_stat <= '0;
		end else if (hit(I_WR, I_ADDR, ADR_IRQ_CLR)) begin
			irq_stat <= (irq_stat & ~I_WDATA[IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat <= irq_stat | irq_set;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			irq_en <= '0;
		end else if (hit(I_WR, I_ADDR, ADR_IRQ_EN)) begin
			irq_en <= I_WDATA[IRQ_W-1:0];
		end
	end

	assign O_IRQ = |(irq_stat & irq_en);

	// controls toward the core, registered
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_SELFTEST_RUN <= 1'b0;
			O_SELFTEST_LONG_SEQ <= 1'b0;
			O_PORT_ADDR <= '0;
			O_TEN_LOOPBACK_EN <= 1'b0;
			O_LINK_PULSE_EN <= 1'b0;
			O_LINK_GOOD_10 <= 1'b0;
			O_HEARTBEAT_EN <= 1'b0;
			O_JABBER_EN <= 1'b0;
			O_PHY_STATUS_REGISTER_POLARITY <= 1'b0;
			O_DUPLEX_IND <= 1'b0;
		end else begin
			O_SELFTEST_RUN <= run;
			O_SELFTEST_LONG_SEQ <= seq_sel;
			O_PORT_ADDR <= port_addr;
			// the control bit only matters with basic loopback asked for
			O_TEN_LOOPBACK_EN <= I_BASIC_LOOPBACK & tb[TB_LB10];
			O_LINK_PULSE_EN <= ~tb[TB_LINK_PULSE_DISABLE];
			O_LINK_GOOD_10 <= tb[TB_FORCE] | I_LINK_MON_10;
			O_HEARTBEAT_EN <= ~I_SPEED_100 & ~I_FULL_DUPLEX & ~tb[TB_HB_DIS];
			O_JABBER_EN <= ~I_SPEED_100 & ~tb[TB_JAB_DIS];
			O_PHY_STATUS_REGISTER_POLARITY <= pol;
			// pin doubles as strap: invert so the lit level opposes the strap
			O_DUPLEX_IND <= duplex_indicator_cfg ? (I_FULL_DUPLEX ^ strap_cfg) : I_FULL_DUPLEX;
		end
	end

	indicator_if ind ();
	assign ind.raw = {I_COL_ACT, I_TX_ACT, I_RX_ACT};
	assign ind.bypass = bypass;
	assign O_RX_IND = ind.led[0];
	assign O_TX_IND = ind.led[1];
	assign O_COL_IND = ind.led[2];

	ind_stretcher #(.STRETCH_CYC(STRETCH_CYC)) u_stretch (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.ind(ind.strt)
	);

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);

	property p_result_clear;
		wr_ctrl && !(run && I_SELFTEST_PASS) |=> !result;
	endproperty
	a_result_clear: assert property (p_result_clear) else $error("result not cleared");
	property p_result_hold;
		result && !wr_ctrl |=> result;
	endproperty
	a_result_hold: assert property (p_result_hold) else $error("result lost");
	property p_bypass;
		bypass && !wr_ctrl ##1 bypass && !I_RX_ACT |=> !O_RX_IND;
	endproperty
	a_bypass: assert property (p_bypass) else $error("stretch not bypassed");
	property p_pause;
		hit(I_RD, I_ADDR, ADR_PHY_CTRL) |=> O_RDATA[PC_PAUSE] == $past(pause) && O_RDATA[PC_ONE];
	endproperty
	a_pause: assert property (p_pause) else $error("pause or fixed bit wrong");
	property p_duplex;
		!duplex_indicator_cfg |=> O_DUPLEX_IND == $past(I_FULL_DUPLEX);
	endproperty
	a_duplex: assert property (p_duplex) else $error("duplex not active high");
	property p_addr;
		wr_ctrl && boot == ST_RUN |-> ##2 O_PORT_ADDR == $past(I_WDATA[PC_ADDR_HI:PC_ADDR_LO], 2);
	endproperty
	a_addr: assert property (p_addr) else $error("address not taken");
	property p_lb10;
		!I_BASIC_LOOPBACK |=> !O_TEN_LOOPBACK_EN;
	endproperty
	a_lb10: assert property (p_lb10) else $error("loopback without basic bit");
	property p_pol;
		rd_tb && !I_POLARITY_INVERTED |=> !pol ##1 !O_PHY_STATUS_REGISTER_POLARITY;
	endproperty
	a_pol: assert property (p_pol) else $error("polarity not cleared");
	property p_heartbeat;
		I_SPEED_100 || I_FULL_DUPLEX |=> !O_HEARTBEAT_EN;
	endproperty
	a_heartbeat: assert property (p_heartbeat) else $error("heartbeat outside half 10");
	property p_upper;
		I_RD && (I_ADDR == ADR_TENBASE || I_ADDR == ADR_PHY_CTRL)
			|=> O_RDATA[DATA_W-1:PC_SEQ_SEL + 1] == '0;
	endproperty
	a_upper: assert property (p_upper) else $error("upper bits not zero");

	c_pass: cover property (run && I_SELFTEST_PASS ##1 result);
	c_pol_clear: cover property (pol && rd_tb ##1 !pol);
	c_irq: cover property (!O_IRQ ##1 O_IRQ);
endmodule // phy_extended_control_regs

//--- phy_extended_control_regs_tb.sv
`timescale 1ns/1ps
module phy_extended_control_regs_tb import phyx_pkg::*;;
	logic I_CLK = 1'b0;
	logic I_RST_N = 1'b0;
	logic [ADDR_W-1:0] I_ADDR = '0;
	logic [DATA_W-1:0] I_WDATA = '0;
	logic I_WR = 1'b0;
	logic I_RD = 1'b0;
	logic [DATA_W-1:0] O_RDATA;
	logic [4:0] I_STRAP_ADDR = 5'h15;
	logic I_STRAP_DUPLEX_INDICATOR_CFG = 1'b1;
	logic I_BASIC_LOOPBACK = 1'b0;
	logic I_SPEED_100 = 1'b0;
	logic I_FULL_DUPLEX = 1'b0;
	logic I_LINK_MON_10 = 1'b0;
	logic I_POLARITY_INVERTED = 1'b0;
	logic I_LOCAL_PAUSE = 1'b0;
	logic I_PARTNER_PAUSE = 1'b0;
	logic I_SELFTEST_PASS = 1'b0;
	logic I_RX_ACT = 1'b0;
	logic I_TX_ACT = 1'b0;
	logic I_COL_ACT = 1'b0;
	logic O_SELFTEST_RUN, O_SELFTEST_LONG_SEQ, O_TEN_LOOPBACK_EN, O_LINK_PULSE_EN;
	logic O_LINK_GOOD_10, O_HEARTBEAT_EN, O_JABBER_EN, O_PHY_STATUS_REGISTER_POLARITY;
	logic O_RX_IND, O_TX_IND, O_COL_IND, O_DUPLEX_IND, O_IRQ;
	logic [4:0] O_PORT_ADDR;
	int num_errors = 0;
	int samples_checked = 0;

	// short stretch keeps the run brief
	phy_extended_control_regs #(.STRETCH_CYC(2)) i_phy_extended_control_regs (
		.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
		.I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_STRAP_ADDR(I_STRAP_ADDR),
		.I_STRAP_DUPLEX_INDICATOR_CFG(I_STRAP_DUPLEX_INDICATOR_CFG), .I_BASIC_LOOPBACK(I_BASIC_LOOPBACK),
		.I_SPEED_100(I_SPEED_100), .I_FULL_DUPLEX(I_FULL_DUPLEX),
		.I_LINK_MON_10(I_LINK_MON_10), .I_POLARITY_INVERTED(I_POLARITY_INVERTED),
		.I_LOCAL_PAUSE(I_LOCAL_PAUSE), .I_PARTNER_PAUSE(I_PARTNER_PAUSE),
		.I_SELFTEST_PASS(I_SELFTEST_PASS), .I_RX_ACT(I_RX_ACT), .I_TX_ACT(I_TX_ACT),
		.I_COL_ACT(I_COL_ACT), .O_SELFTEST_RUN(O_SELFTEST_RUN),
		.O_SELFTEST_LONG_SEQ(O_SELFTEST_LONG_SEQ), .O_PORT_ADDR(O_PORT_ADDR),
		.O_TEN_LOOPBACK_EN(O_TEN_LOOPBACK_EN), .O_LINK_PULSE_EN(O_LINK_PULSE_EN),
		.O_LINK_GOOD_10(O_LINK_GOOD_10), .O_HEARTBEAT_EN(O_HEARTBEAT_EN),
		.O_JABBER_EN(O_JABBER_EN), .O_PHY_STATUS_REGISTER_POLARITY(O_PHY_STATUS_REGISTER_POLARITY),
		.O_RX_IND(O_RX_IND), .O_TX_IND(O_TX_IND), .O_COL_IND(O_COL_IND),
		.O_DUPLEX_IND(O_DUPLEX_IND), .O_IRQ(O_IRQ)
	);

	always #2.5 I_CLK = ~I_CLK;

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge I_CLK);
		#1;
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge I_CLK);
		I_WR <= 1'b1;
		I_ADDR <= a;
		I_WDATA <= d;
		@(posedge I_CLK);
		I_WR <= 1'b0;
	endtask

	// data is sampled in the single cycle after the strobe
	task automatic rdc(input logic [4:0] a, input logic [15:0] exp, input string name);
		@(posedge I_CLK);
		I_RD <= 1'b1;
		I_ADDR <= a;
		@(posedge I_CLK);
		I_RD <= 1'b0;
		#1;
		check(name, O_RDATA, exp);
	endtask

	// one-cycle activity burst, indicators looked at one edge after it ends
	task automatic act_pulse(input logic [2:0] exp);
		@(posedge I_CLK);
		{I_RX_ACT, I_TX_ACT, I_COL_ACT} <= 3'b111;
		@(posedge I_CLK);
		{I_RX_ACT, I_TX_ACT, I_COL_ACT} <= 3'b000;
		cyc(1);
		check("indicators", {13'h0, O_RX_IND, O_TX_IND, O_COL_IND}, {13'h0, exp});
	endtask

	task automatic stop_test;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		#20000;
		num_errors++;
		stop_test();
	end

	initial begin
		logic [15:0] exp;
		repeat (12) @(posedge I_CLK);
		I_RST_N <= 1'b1;
		cyc(6);
		rdc(ADR_PHY_CTRL, 16'h0075, "phy ctrl reset");
		check("port addr", {11'h0, O_PORT_ADDR}, 16'h0015);
		rdc(ADR_TENBASE, 16'h0004, "tenbase reset");
		rdc(5'h00, 16'h0000, "unmapped");
		@(posedge I_CLK);
		I_FULL_DUPLEX <= 1'b1;
		cyc(2);
		check("duplex inv fd", {15'h0, O_DUPLEX_IND}, 16'h0000);
		@(posedge I_CLK);
		I_FULL_DUPLEX <= 1'b0;
		cyc(2);
		check("duplex inv hd", {15'h0, O_DUPLEX_IND}, 16'h0001);
		@(posedge I_CLK);
		I_LOCAL_PAUSE <= 1'b1;
		I_PARTNER_PAUSE <= 1'b1;
		wr(ADR_PHY_CTRL, 16'hFFFF);
		cyc(2);
		exp = {9'h0, O_SELFTEST_RUN, O_SELFTEST_LONG_SEQ, O_PORT_ADDR};
		check("run seq addr", exp, 16'h007F);
		rdc(ADR_PHY_CTRL, 16'h0BFF, "phy ctrl all ones");
		@(posedge I_CLK);
		I_PARTNER_PAUSE <= 1'b0;
		cyc(2);
		rdc(ADR_PHY_CTRL, 16'h0B7F, "pause one side");
		@(posedge I_CLK);
		I_SELFTEST_PASS <= 1'b1;
		cyc(3);
		@(posedge I_CLK);
		I_SELFTEST_PASS <= 1'b0;
		cyc(2);
		rdc(ADR_PHY_CTRL, 16'h0F7F, "result pass");
		rdc(ADR_PHY_CTRL, 16'h0F7F, "result held");
		wr(ADR_PHY_CTRL, 16'h0100);
		cyc(2);
		exp = {9'h0, O_SELFTEST_RUN, O_SELFTEST_LONG_SEQ, O_PORT_ADDR};
		check("run stop", exp, 16'h0000);
		rdc(ADR_PHY_CTRL, 16'h0140, "result cleared");
		@(posedge I_CLK);
		I_FULL_DUPLEX <= 1'b1;
		cyc(2);
		check("duplex plain", {15'h0, O_DUPLEX_IND}, 16'h0001);
		act_pulse(3'b000);
		wr(ADR_PHY_CTRL, 16'h0000);
		cyc(2);
		act_pulse(3'b111);
		cyc(6);
		check("stretch ends", {13'h0, O_RX_IND, O_TX_IND, O_COL_IND}, 16'h0000);
		// interrupt status, enable and clear
		rdc(ADR_IRQ_STAT, 16'h0002, "irq stat pass");
		check("irq masked", {15'h0, O_IRQ}, 16'h0000);
		wr(ADR_IRQ_EN, 16'h0007);
		cyc(1);
		check("irq on", {15'h0, O_IRQ}, 16'h0001);
		rdc(ADR_IRQ_EN, 16'h0007, "irq enable");
		wr(ADR_IRQ_CLR, 16'h0002);
		cyc(1);
		check("irq cleared", {15'h0, O_IRQ}, 16'h0000);
		rdc(ADR_IRQ_STAT, 16'h0000, "irq stat clear");
		@(posedge I_CLK);
		I_POLARITY_INVERTED <= 1'b1;
		@(posedge I_CLK);
		I_POLARITY_INVERTED <= 1'b0;
		cyc(2);
		check("phy_status_register pol", {15'h0, O_PHY_STATUS_REGISTER_POLARITY}, 16'h0001);
		check("irq pol", {15'h0, O_IRQ}, 16'h0001);
		rdc(ADR_TENBASE, 16'h0014, "pol latched");
		cyc(2);
		check("phy_status_register clr", {15'h0, O_PHY_STATUS_REGISTER_POLARITY}, 16'h0000);
		rdc(ADR_TENBASE, 16'h0004, "pol cleared");
		wr(ADR_IRQ_CLR, 16'h0001);
		wr(ADR_RSVD_A, 16'h1234);
		cyc(1);
		rdc(ADR_IRQ_STAT, 16'h0004, "rsvd write flag");
		check("irq rsvd", {15'h0, O_IRQ}, 16'h0001);
		wr(ADR_IRQ_EN, 16'h0000);
		cyc(1);
		check("irq mask", {15'h0, O_IRQ}, 16'h0000);
		rdc(ADR_RSVD_A, 16'h1234, "rsvd storage");
		wr(ADR_IRQ_CLR, 16'h0004);
		rdc(ADR_IRQ_STAT, 16'h0000, "irq stat end");
		wr(ADR_TENBASE, 16'hFFFF);
		rdc(ADR_TENBASE, 16'h01EF, "tenbase ones");
		// every speed, duplex and loopback mix, controls clear then set
		for (int k = 0; k < 16; k++) begin
			logic [3:0] s;
			s = k[3:0];
			if (s[2:0] == 3'b000) begin
				wr(ADR_TENBASE, s[3] ? 16'h01C7 : 16'h0004);
			end
			@(posedge I_CLK);
			I_SPEED_100 <= s[0];
			I_FULL_DUPLEX <= s[1];
			I_BASIC_LOOPBACK <= s[2];
			I_LINK_MON_10 <= s[0] ^ s[2];
			cyc(3);
			exp = {11'h0, s[3] & s[2], ~s[3], s[3] | (s[0] ^ s[2]),
				~s[3] & ~s[0] & ~s[1], ~s[3] & ~s[0]};
			check("ten outs", {11'h0, O_TEN_LOOPBACK_EN, O_LINK_PULSE_EN, O_LINK_GOOD_10,
				O_HEARTBEAT_EN, O_JABBER_EN}, exp);
		end
		stop_test();
	end
endmodule // phy_extended_control_regs_tb
